// ==== hdl/clr_consts.svh ====
`ifndef CLR_CONSTS_SVH
`define CLR_CONSTS_SVH
// pressure in units of 0.01 bar
`define CLR_MIN_GAP 16'h0014
`define CLR_CUT_OUT_RST 16'h03E8
`define CLR_CUT_IN_RST 16'h03D4
`define CLR_SVC_MAX 16'h270F
`define CLR_SVC_RST 16'h07D0
`define CLR_SOFT_STOP_S 30
`define CLR_RUN_ON_RST 16'h003C
`define CLR_CLK_HZ 100000000
`define CLR_SEC_CYC (`CLR_CLK_HZ)
`define CLR_HOUR_S 3600
`define CLR_SLOW_DIV 5'h18
`define CLR_FAST_DIV 5'h16
`endif

// ==== hdl/clr_pkg.sv ====
package clr_pkg;
    typedef enum logic [2:0] {
        CLR_IDLE = 3'b000,
        CLR_ARMED = 3'b001,
        CLR_LOADED = 3'b010,
        CLR_UNLOADED = 3'b011,
        CLR_RUN_ON = 3'b100,
        CLR_SOFT_STOP = 3'b101
    } clr_state_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic ack;
        logic up;
        logic down;
    } clr_keys_t;
    typedef struct packed {
        logic red;
        logic green;
    } clr_lamps_t;
endpackage

// ==== hdl/clr_ctrl.sv ====
// Operation
// R1 - unload at upper pressure threshold
// R2 - reload at lower pressure threshold
// R3 - refuse thresholds closer than 0.2
// R4 - stop key gives 30 s soft stop
// R5 - always-run mode idles unloaded, never stops
// R6 - demand-stop unloads, counts run-on, stops
// R7 - demand during run-on resumes loaded running
// R8 - warning flashes red slowly, no halt_on_service_option
// R9 - warning cleared by ack after cause gone
// R10 - fault shuts down or blocks start
// R11 - fault latched until cause gone and ack
// R12 - start key needed after clearing
// R13 - emergency off stops immediately
// R14 - service due shows notice, keeps running
// R15 - halt option stops on service due
// R16 - four programmable service intervals
// R17 - above 9999 hours disables interval
// R18 - total hours count loaded and unloaded
// R19 - loaded hours count loaded only
// R20 - settings commit only on confirm ack
// R21 - calendar fields edited in fixed order
// R22 - fault flashes red fast, stays stopped
// R23 - green flashes armed, steady when running
// R24 - load state holds between thresholds
// R25 - hour tick only while motor runs
`timescale 1ns/100ps
`default_nettype none
`include "clr_consts.svh"
module clr_ctrl
    import clr_pkg::*;
#(
    parameter int SEC_CYC = `CLR_SEC_CYC,
    parameter int HOUR_S = `CLR_HOUR_S
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire clr_keys_t keys,
    input wire logic estop,
    input wire logic [15:0] net_pressure,
    input wire logic warn_cause,
    input wire logic fault_cause,
    input wire logic demand_stop_mode,
    input wire logic halt_on_service_option,
    input wire logic [2:0] edit_sel,
    output logic motor_on,
    output logic load_valve,
    output clr_lamps_t lamps,
    output logic [15:0] countdown_s,
    output logic warn_shown,
    output logic fault_latched,
    output logic service_due_notice,
    output logic [3:0] svc_disabled,
    output logic [15:0] cut_out_q,
    output logic [15:0] cut_in_q,
    output logic setting_refused,
    output logic editing,
    output logic [15:0] edit_value,
    output logic [2:0] cal_field,
    output logic [31:0] total_hours,
    output logic [31:0] loaded_hours
);
    localparam int SOFT_CYC = `CLR_SOFT_STOP_S;

    clr_state_t state_q;
    logic [31:0] sec_cnt_q;
    logic sec_tick;
    logic [15:0] hour_sec_q;
    logic hour_tick;
    logic [15:0] svc_q [4];
    logic [15:0] svc_left_q [4];
    logic [3:0] svc_hit;
    logic [15:0] run_on_q;
    logic slow_ph_q;
    logic fast_ph;
    logic [15:0] load_sec_q;
    logic running;
    logic ack_p, start_p, stop_p;

    assign ack_p = keys.ack;
    assign start_p = keys.start;
    assign stop_p = keys.stop;
    assign running = state_q inside {CLR_LOADED, CLR_UNLOADED, CLR_RUN_ON, CLR_SOFT_STOP};

    // one-second timebase, frozen with ce; flash phases come from it so they scale with SEC_CYC
    always_ff @(posedge clk) begin
        if (rst) begin
            sec_cnt_q <= 32'h0000_0000;
            slow_ph_q <= 1'b0;
        end else if (ce) begin
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            slow_ph_q <= slow_ph_q ^ sec_tick;
        end
    end
    assign sec_tick = (sec_cnt_q == 32'(SEC_CYC - 1));
    assign fast_ph = (sec_cnt_q < 32'(SEC_CYC / 4)) ||
                     ((sec_cnt_q >= 32'(SEC_CYC / 2)) && (sec_cnt_q < 32'(3 * SEC_CYC / 4)));

    // R25 hour from seconds; only counted while the motor turns
    always_ff @(posedge clk) begin
        if (rst) begin
            hour_sec_q <= 16'h0000;
        end else if (ce && sec_tick && running) begin
            hour_sec_q <= hour_tick ? 16'h0000 : hour_sec_q + 16'h0001;
        end
    end
    assign hour_tick = sec_tick && running && (hour_sec_q == 16'(HOUR_S - 1));

    // R9 R11 warning and fault latches; set wins over ack
    always_ff @(posedge clk) begin
        if (rst) begin
            warn_shown <= 1'b0;
            fault_latched <= 1'b0;
        end else if (ce) begin
            if (warn_cause) begin
                warn_shown <= 1'b1;
            end else if (ack_p) begin
                warn_shown <= 1'b0;
            end
            if (fault_cause || estop) begin
                fault_latched <= 1'b1;
            end else if (ack_p && !editing) begin
                fault_latched <= 1'b0;
            end
        end
    end

    // R20 edit session: ack opens, up/down adjust, ack commits
    // sel 0 cut-out, 1 cut-in, 2..5 service intervals, 6 calendar
    always_ff @(posedge clk) begin
        if (rst) begin
            editing <= 1'b0;
            edit_value <= 16'h0000;
            cal_field <= 3'h0;
            cut_out_q <= `CLR_CUT_OUT_RST;
            cut_in_q <= `CLR_CUT_IN_RST;
            setting_refused <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                svc_q[i] <= `CLR_SVC_RST;
            end
        end else if (ce) begin
            if (!editing && ack_p && !warn_shown && !fault_latched) begin
                editing <= 1'b1;
                setting_refused <= 1'b0;
                edit_value <= (edit_sel == 3'h0) ? cut_out_q :
                              (edit_sel == 3'h1) ? cut_in_q :
                              (edit_sel < 3'h6) ? svc_q[2'(edit_sel - 3'h2)] : 16'h0000;
            end else if (editing && keys.up) begin
                edit_value <= edit_value + 16'h0001;
            end else if (editing && keys.down) begin
                edit_value <= edit_value - 16'h0001;
            end else if (editing && ack_p) begin
                editing <= 1'b0;
                case (edit_sel)
                    3'h0: begin
                        // R3 refuse a narrow band
                        if ({1'b0, edit_value} >= {1'b0, cut_in_q} + 17'(`CLR_MIN_GAP)) begin
                            cut_out_q <= edit_value;
                        end else begin
                            setting_refused <= 1'b1;
                        end
                    end
                    3'h1: begin
                        if ({1'b0, cut_out_q} >= {1'b0, edit_value} + 17'(`CLR_MIN_GAP)) begin
                            cut_in_q <= edit_value;
                        end else begin
                            setting_refused <= 1'b1;
                        end
                    end
                    3'h2, 3'h3, 3'h4, 3'h5: begin
                        // R16 one of four intervals
                        svc_q[2'(edit_sel - 3'h2)] <= edit_value;
                    end
                    3'h6: begin
                        // R21 day of week (0) through seconds (6), then wrap
                        cal_field <= (cal_field == 3'h6) ? 3'h0 : cal_field + 3'h1;
                    end
                    default: begin
                        setting_refused <= 1'b1;
                    end
                endcase
            end
        end
    end

    // per-interval countdown and disable flag
    generate
        for (genvar g = 0; g < 4; g++) begin : g_svc
            // R17 above 9999 disables monitoring
            assign svc_hit[g] = (svc_q[g] <= `CLR_SVC_MAX) && (svc_left_q[g] == 16'h0000);
            always_ff @(posedge clk) begin
                if (rst) begin
                    svc_left_q[g] <= `CLR_SVC_RST;
                    svc_disabled[g] <= 1'b0;
                end else if (ce) begin
                    svc_disabled[g] <= (svc_q[g] > `CLR_SVC_MAX);
                    if (editing && ack_p && edit_sel == 3'(g + 2)) begin
                        svc_left_q[g] <= edit_value;
                    // R25 countdown on running hours
                    end else if (hour_tick && svc_left_q[g] != 16'h0000) begin
                        svc_left_q[g] <= svc_left_q[g] - 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // R14 notice only; running is left to the state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            service_due_notice <= 1'b0;
        end else if (ce) begin
            service_due_notice <= |svc_hit;
        end
    end

    // R18 R19 hour counters; loaded time keeps its own seconds so part-loaded hours stay exact
    always_ff @(posedge clk) begin
        if (rst) begin
            total_hours <= 32'h0000_0000;
            loaded_hours <= 32'h0000_0000;
            load_sec_q <= 16'h0000;
        end else if (ce) begin
            if (hour_tick) begin
                total_hours <= total_hours + 32'h0000_0001;
            end
            if (sec_tick && state_q == CLR_LOADED) begin
                load_sec_q <= (load_sec_q == 16'(HOUR_S - 1)) ? 16'h0000 : load_sec_q + 16'h0001;
                if (load_sec_q == 16'(HOUR_S - 1)) begin
                    loaded_hours <= loaded_hours + 32'h0000_0001;
                end
            end
        end
    end

    // main run state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CLR_IDLE;
            run_on_q <= 16'h0000;
        end else if (ce) begin
            // R13 R10 R22 emergency off and faults bypass soft stop
            if (estop || fault_latched || fault_cause ||
                (halt_on_service_option && (|svc_hit))) begin
                // R15 halt on service due
                state_q <= CLR_IDLE;
                run_on_q <= 16'h0000;
            end else begin
                case (state_q)
                    CLR_IDLE: begin
                        // R12 start key arms once clear
                        if (start_p && !warn_shown) begin
                            state_q <= CLR_ARMED;
                        end
                    end
                    CLR_ARMED: begin
                        if (stop_p) begin
                            state_q <= CLR_IDLE;
                        end else if (net_pressure <= cut_in_q) begin
                            state_q <= CLR_LOADED;
                        end
                    end
                    CLR_LOADED: begin
                        if (stop_p) begin
                            state_q <= CLR_SOFT_STOP;
                            run_on_q <= 16'(SOFT_CYC);
                        // R1 R24 unload only at the upper threshold
                        end else if (net_pressure >= cut_out_q) begin
                            state_q <= demand_stop_mode ? CLR_RUN_ON : CLR_UNLOADED;
                            run_on_q <= `CLR_RUN_ON_RST;
                        end
                    end
                    CLR_UNLOADED: begin
                        // R5 always-run idles here; R2 reload at cut-in
                        if (stop_p) begin
                            state_q <= CLR_SOFT_STOP;
                            run_on_q <= 16'(SOFT_CYC);
                        end else if (net_pressure <= cut_in_q) begin
                            state_q <= CLR_LOADED;
                        end else if (demand_stop_mode) begin
                            state_q <= CLR_RUN_ON;
                            run_on_q <= `CLR_RUN_ON_RST;
                        end
                    end
                    CLR_RUN_ON: begin
                        if (stop_p) begin
                            state_q <= CLR_SOFT_STOP;
                            run_on_q <= 16'(SOFT_CYC);
                        // R7 demand back during run-on
                        end else if (net_pressure <= cut_in_q) begin
                            state_q <= CLR_LOADED;
                        // R6 run-on expiry stops motor, stays armed
                        end else if (sec_tick) begin
                            if (run_on_q <= 16'h0001) begin
                                state_q <= CLR_ARMED;
                            end
                            run_on_q <= run_on_q - 16'h0001;
                        end
                    end
                    CLR_SOFT_STOP: begin
                        // R4 30 s unloaded before stopping
                        if (sec_tick) begin
                            if (run_on_q <= 16'h0001) begin
                                state_q <= CLR_IDLE;
                            end
                            run_on_q <= run_on_q - 16'h0001;
                        end
                    end
                    default: state_q <= CLR_IDLE;
                endcase
            end
        end
    end

    // registered outputs; flash phases come from the second timebase
    always_ff @(posedge clk) begin
        if (rst) begin
            motor_on <= 1'b0;
            load_valve <= 1'b0;
            countdown_s <= 16'h0000;
            lamps <= '0;
        end else if (ce) begin
            motor_on <= running;
            load_valve <= (state_q == CLR_LOADED);
            countdown_s <= run_on_q;
            // R22 R8 fast for fault, slow for warning or service
            if (fault_latched) begin
                lamps.red <= fast_ph;
            end else if (warn_shown || service_due_notice) begin
                lamps.red <= slow_ph_q;
            end else begin
                lamps.red <= 1'b0;
            end
            // R23 steady running, flashing armed
            lamps.green <= running | ((state_q == CLR_ARMED) & slow_ph_q);
        end
    end

    // R8 a warning never forces the motor off
    warn_no_stop_a: assert property (@(posedge clk) disable iff (rst) // R8
        ce && running && !fault_cause && !fault_latched && !estop && !stop_p &&
        !halt_on_service_option && (state_q != CLR_SOFT_STOP) && warn_shown
        |=> (state_q != CLR_IDLE)) else $error("warning stopped motor");
    // R13 estop idles next cycle
    estop_stops_a: assert property (@(posedge clk) disable iff (rst) // R13
        ce && estop |=> state_q == CLR_IDLE) else $error("estop ignored");
    // R1 unload at cut-out
    unload_high_a: assert property (@(posedge clk) disable iff (rst) // R1
        ce && state_q == CLR_LOADED && net_pressure >= cut_out_q && !stop_p &&
        !estop && !fault_latched && !fault_cause && !halt_on_service_option
        |=> state_q inside {CLR_UNLOADED, CLR_RUN_ON}) else $error("no unload");
    // R3 band always wide enough
    band_gap_a: assert property (@(posedge clk) disable iff (rst) // R3
        cut_out_q >= cut_in_q + `CLR_MIN_GAP) else $error("band too narrow");
    // R19 loaded counter never passes total
    hours_order_a: assert property (@(posedge clk) disable iff (rst) // R19
        loaded_hours <= total_hours) else $error("loaded above total");
    // R10 fault blocks start
    fault_block_a: assert property (@(posedge clk) disable iff (rst) // R10
        ce && fault_latched |=> !running) else $error("ran with fault");
    // R5 always-run stays unloaded without demand
    always_run_a: assert property (@(posedge clk) disable iff (rst) // R5
        ce && state_q == CLR_UNLOADED && !demand_stop_mode && !stop_p && !estop &&
        !fault_latched && !fault_cause && !halt_on_service_option &&
        net_pressure > cut_in_q |=> state_q == CLR_UNLOADED) else $error("stopped");
    // R23 green steady while running
    green_run_a: assert property (@(posedge clk) disable iff (rst) // R23
        ce && running ##1 1'b1 |-> lamps.green) else $error("green off");
endmodule
`default_nettype wire

// ==== test/clr_operator_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module clr_operator_model
    import clr_pkg::*;
(
    input wire logic clk,
    output clr_keys_t keys,
    output logic [15:0] net_pressure,
    output logic warn_cause,
    output logic fault_cause,
    output logic estop
);
    // idle levels: no key down, pressure inside the band, no cause present
    initial begin
        keys = 5'h00;
        net_pressure = 16'h03DE;
        warn_cause = 1'h0;
        fault_cause = 1'h0;
        estop = 1'h0;
    end
    // one-cycle key press
    // a gap cycle follows so that two presses never merge into one long press
    task automatic press(input clr_keys_t k);
        @(negedge clk);
        keys = k;
        @(negedge clk);
        keys = 5'h00;
        @(negedge clk);
    endtask
    // sensor value only moves between clock edges
    task automatic set_p(input logic [15:0] v);
        @(negedge clk);
        net_pressure = v;
    endtask
    task automatic set_cause(input logic w, input logic f, input logic e);
        @(negedge clk);
        warn_cause = w;
        fault_cause = f;
        estop = e;
    endtask
endmodule
`default_nettype wire

// ==== test/clr_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module clr_ctrl_tb;
    import clr_pkg::*;
    localparam clr_keys_t K_START = 5'h10;
    localparam clr_keys_t K_STOP = 5'h08;
    localparam clr_keys_t K_ACK = 5'h04;
    localparam clr_keys_t K_UP = 5'h02;
    localparam clr_keys_t K_DOWN = 5'h01;
    // thresholds after the edits below: cut-in lowered by 2, cut-out by 2
    localparam logic [15:0] CI = 16'h03D4 - 16'h0002;
    localparam logic [15:0] CO = 16'h03E8 - 16'h0002;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic demand_stop_mode = 1'h0;
    logic halt_on_service_option = 1'h0;
    logic [2:0] edit_sel = 3'h0;
    logic ce = 1'h1;
    clr_keys_t keys;
    clr_lamps_t lamps;
    logic [15:0] net_pressure, countdown_s, cut_out_q, cut_in_q, edit_value;
    logic warn_cause, fault_cause, estop, motor_on, load_valve, warn_shown, fault_latched;
    logic service_due_notice, setting_refused, editing;
    logic [3:0] svc_disabled;
    logic [2:0] cal_field;
    logic [31:0] total_hours, loaded_hours, t0, l0;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int nf;
    int seed = 32'h84dc_5ec1;
    logic ph;
    // short second and hour keep the run within budget
    clr_ctrl #(.SEC_CYC(10), .HOUR_S(3)) uut (.clk(clk), .rst(rst), .ce(ce), .keys(keys),
        .estop(estop), .net_pressure(net_pressure), .warn_cause(warn_cause),
        .fault_cause(fault_cause), .demand_stop_mode(demand_stop_mode),
        .halt_on_service_option(halt_on_service_option), .edit_sel(edit_sel),
        .motor_on(motor_on), .load_valve(load_valve), .lamps(lamps), .countdown_s(countdown_s),
        .warn_shown(warn_shown), .fault_latched(fault_latched),
        .service_due_notice(service_due_notice), .svc_disabled(svc_disabled),
        .cut_out_q(cut_out_q), .cut_in_q(cut_in_q), .setting_refused(setting_refused),
        .editing(editing), .edit_value(edit_value), .cal_field(cal_field),
        .total_hours(total_hours), .loaded_hours(loaded_hours));
    clr_operator_model op (.clk(clk), .keys(keys), .net_pressure(net_pressure),
        .warn_cause(warn_cause), .fault_cause(fault_cause), .estop(estop));
    always #5 clk = ~clk;
    // hang guard, well above the expected length of the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait on motor_on (sel 0) or load_valve (sel 1)
    task automatic wait_out(input logic sel, input logic v, input int lim);
        int n;
        n = 0;
        while (((sel ? load_valve : motor_on) !== v) && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // count changes of the red (sel 0) or green (sel 1) lamp over n cycles
    task automatic flashes(input logic sel, input int n, output int c);
        logic prev;
        prev = sel ? lamps.green : lamps.red;
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if ((sel ? lamps.green : lamps.red) !== prev) begin
                c++;
            end
            prev = sel ? lamps.green : lamps.red;
        end
    endtask
    task automatic edit(input logic [2:0] sel, input clr_keys_t k, input int n);
        @(negedge clk);
        edit_sel = sel;
        op.press(K_ACK);
        repeat (n) op.press(k);
        op.press(K_ACK);
        idle(2);
    endtask
    task automatic start_run();
        op.set_p(CI - 16'h0050);
        op.press(K_START);
        wait_out(1'h0, 1'h1, 20);
    endtask
    // random pressure strictly between the two thresholds
    function automatic logic [15:0] band_p();
        return CI + 16'h0001 + 16'(($random(seed) & 32'h0000_7fff) % 19);
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        idle(2);
        chk("cut_out_q", 32'h0000_03E8, cut_out_q);
        chk("cut_in_q", 32'h0000_03D4, cut_in_q);
        $display("test reset done");
        // gap of 19 is refused, edits only land on confirmation
        edit_sel = 3'h1;
        op.press(K_ACK);
        op.press(K_UP);
        chk("editing", 32'h1, editing);
        chk("edit_value", 32'h0000_03D5, edit_value);
        chk("cut_in_q", 32'h0000_03D4, cut_in_q);
        op.press(K_ACK);
        idle(2);
        chk("cut_in_q", 32'h0000_03D4, cut_in_q);
        chk("setting_refused", 32'h1, setting_refused);
        edit(3'h1, K_DOWN, 2);
        edit(3'h0, K_DOWN, 2);
        chk("cut_in_q", 32'(CI), cut_in_q);
        chk("cut_out_q", 32'(CO), cut_out_q);
        chk("setting_refused", 32'h0, setting_refused);
        $display("test settings done");
        // an unused select is refused; each calendar commit moves on one field
        edit(3'h7, K_UP, 0);
        chk("setting_refused", 32'h1, setting_refused);
        edit(3'h6, K_UP, 1);
        chk("cal_field", 32'h1, cal_field);
        chk("setting_refused", 32'h0, setting_refused);
        repeat (6) edit(3'h6, K_UP, 0);
        chk("cal_field", 32'h0, cal_field);
        $display("test calendar done");
        // 9999 still monitored, one more disables
        edit(3'h3, K_UP, 7999);
        chk("svc_disabled", 32'h0, svc_disabled);
        edit(3'h3, K_UP, 1);
        chk("svc_disabled", 32'h2, svc_disabled);
        $display("test service_limit done");
        op.set_p(CI - 16'h0050);
        idle(20);
        chk("motor_on", 32'h0, motor_on);
        start_run();
        chk("motor_on", 32'h1, motor_on);
        chk("green", 32'h1, lamps.green);
        for (int p = 0; p < 2; p++) begin
            ph = p[0];
            repeat (4) begin
                op.set_p(band_p());
                idle(5 + ($random(seed) & 32'h0000_000f));
                chk("load_valve", 32'(!ph), load_valve);
            end
            op.set_p(ph ? CI : CO);
            wait_out(1'h1, ph, 10);
            chk("load_valve", 32'(ph), load_valve);
        end
        $display("test load done");
        op.set_p(CO);
        wait_out(1'h1, 1'h0, 10);
        t0 = total_hours;
        l0 = loaded_hours;
        idle(700);
        chk("motor_on", 32'h1, motor_on);
        chk("loaded_hours", l0, loaded_hours);
        chk("total_step", 32'h1, 32'(total_hours - t0 >= 22 && total_hours - t0 <= 24));
        $display("test counters done");
        op.set_cause(1'h1, 1'h0, 1'h0);
        flashes(1'h0, 60, nf);
        chk("red_slow", 32'h1, 32'(nf >= 4 && nf <= 7));
        chk("warn_shown", 32'h1, warn_shown);
        chk("motor_on", 32'h1, motor_on);
        op.press(K_ACK);
        chk("warn_shown", 32'h1, warn_shown);
        op.set_cause(1'h0, 1'h0, 1'h0);
        op.press(K_ACK);
        idle(2);
        chk("warn_shown", 32'h0, warn_shown);
        $display("test warning done");
        demand_stop_mode = 1'h1;
        idle(50);
        chk("countdown_s", 32'h1, 32'(countdown_s >= 16'h0032 && countdown_s <= 16'h003C));
        chk("motor_on", 32'h1, motor_on);
        // with ce low the run-on count must not move
        t0 = 32'(countdown_s);
        ce = 1'h0;
        idle(40);
        ce = 1'h1;
        idle(2);
        chk("countdown_hold", 32'h1, 32'(t0 - 32'(countdown_s) <= 32'h1));
        op.set_p(CI);
        wait_out(1'h1, 1'h1, 10);
        chk("load_valve", 32'h1, load_valve);
        op.set_p(CO);
        wait_out(1'h0, 1'h0, 700);
        chk("motor_on", 32'h0, motor_on);
        flashes(1'h1, 30, nf);
        chk("green_armed", 32'h1, 32'(nf >= 2));
        op.set_p(CI);
        wait_out(1'h0, 1'h1, 20);
        chk("motor_on", 32'h1, motor_on);
        demand_stop_mode = 1'h0;
        $display("test run_on done");
        op.press(K_STOP);
        idle(280);
        chk("motor_on", 32'h1, motor_on);
        wait_out(1'h0, 1'h0, 50);
        chk("motor_on", 32'h0, motor_on);
        t0 = total_hours;
        idle(100);
        chk("total_hours", t0, total_hours);
        $display("test soft_stop done");
        start_run();
        op.set_cause(1'h0, 1'h1, 1'h0);
        wait_out(1'h0, 1'h0, 5);
        chk("motor_on", 32'h0, motor_on);
        op.set_cause(1'h0, 1'h0, 1'h0);
        op.press(K_START);
        flashes(1'h0, 10, nf);
        chk("red_fast", 32'h1, 32'(nf >= 3));
        chk("motor_on", 32'h0, motor_on);
        chk("fault_latched", 32'h1, fault_latched);
        op.press(K_ACK);
        idle(10);
        chk("fault_latched", 32'h0, fault_latched);
        chk("motor_on", 32'h0, motor_on);
        $display("test fault done");
        start_run();
        op.set_cause(1'h0, 1'h0, 1'h1);
        wait_out(1'h0, 1'h0, 3);
        chk("motor_on", 32'h0, motor_on);
        op.set_cause(1'h0, 1'h0, 1'h0);
        op.press(K_ACK);
        start_run();
        chk("motor_on", 32'h1, motor_on);
        $display("test estop done");
        edit(3'h2, K_DOWN, 1999);
        idle(45);
        chk("service_due_notice", 32'h1, service_due_notice);
        chk("motor_on", 32'h1, motor_on);
        chk("loaded_grew", 32'h1, 32'(loaded_hours > l0));
        halt_on_service_option = 1'h1;
        wait_out(1'h0, 1'h0, 5);
        chk("motor_on", 32'h0, motor_on);
        $display("test service done");
        end_of_test();
    end
endmodule
`default_nettype wire
